// ==== design/rilar_engine.sv ====
// Auto refresh engine between CPU device memory and link master buffers
// Function
// - Auto refresh covers at most eight master modules; more need explicit buffer access.
// - Engine raises each configured module's link start output by itself.
// - Batch refresh runs after end of scan only in run, pause or step-run.
// - Link start rises only after a full first scan in run, pause or step-run.
// - Module with hardware or ROM error is skipped.
// - Module count 0 to 8; zero disables auto refresh.
// - Legacy mode occupies 32 I/O points, extended mode 48.
// - Station total goes to word 0 in legacy only; extended uses master value.
// - Receive words 110-141 go to device; send area goes to words 10-41.
// - Eight points per station, odd counts rounded up by one station.
// - Retry count 0 to 32, default 5, written to word 1.
// - Link priority makes buffer access wait, bounded by 0.3 ms plus 0.2 ms/station; longer waits only set wait_overrun.
// - CPU priority, the default, lets buffer access preempt the link.
// - Faulty station data select: retain last data or clear, default clear.
// - Fault detection words 100-103, plus 195 in extended mode, copied when configured.
// - Error code word 107, or 196 onward in extended mode, copied when configured.
// - Line error send method written to word 4, default retain.
// - While CPU stopped the link stops or continues as configured, default stop.
// - Receive padding refreshed but forced off; spare send points written only.
// - Separate refresh modules and terminal units stay outside auto refresh.
`timescale 1ns/10ps
module rilar_engine
  import rilar_pkg::*;
#(
  parameter int WAIT_BASE = WAIT_BASE_CYC,
  parameter int WAIT_STEP = WAIT_STEP_CYC
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  rilar_cpu_type      cpu_state,
  input  wire logic          end_of_scan,
  input  wire logic [3:0]    module_count,
  input  wire logic          cfg_stop_continue,
  input  wire logic          cfg_link_priority,
  input  wire logic          cfg_retain_faulty,
  input  wire logic [6:0]    cfg_sep_stations,
  input  wire logic          cfg_wr,
  input  wire logic [2:0]    cfg_idx,
  input  wire logic          cfg_legacy,
  input  wire logic [6:0]    cfg_stations,
  input  wire logic [5:0]    cfg_retries,
  input  rilar_line_err_type cfg_line_err,
  input  wire logic [15:0]   cfg_rx_head,
  input  wire logic [15:0]   cfg_tx_head,
  input  wire logic          cfg_fault_en,
  input  wire logic [15:0]   cfg_fault_head,
  input  wire logic          cfg_err_en,
  input  wire logic [15:0]   cfg_err_head,
  input  wire logic [2:0]    cfg_rt_mods,
  input  wire logic [7:0]    hw_error,
  input  wire logic [7:0]    rom_error,
  output logic [7:0]         link_start,
  output logic [7:0]         access_priority_select,
  output logic [7:0]         faulty_station_clear_select,
  output logic [8:0]         io_points_total,
  output logic               busy,
  output logic               wait_overrun,
  output logic               buf_req,
  output logic               buf_we,
  output logic [2:0]         buf_mod,
  output logic [9:0]         buf_addr,
  output logic [15:0]        buf_wdata,
  input  wire logic          buf_ack,
  input  wire logic [15:0]   buf_rdata,
  output logic               dev_req,
  output logic               dev_we,
  output logic [15:0]        dev_addr,
  output logic [15:0]        dev_wdata,
  input  wire logic          dev_ack,
  input  wire logic [15:0]   dev_rdata
);
  typedef struct packed {
    rilar_state_type st;
    rilar_seg_type   seg;
    logic [2:0]      mod;
    logic [5:0]      idx;
    logic [5:0]      cnt;
    logic [6:0]      stations;
    logic            started;
    logic [7:0]      legacy;
    logic [7:0]      start;
    logic [7:0]      prio;
    logic [7:0]      retain;
    logic [8:0]      points;
    logic [19:0]     wait_cnt;
    logic            overrun;
  } rilar_eng_type;

  rilar_eng_type s_r;
  rilar_eng_type s_nxt;
  rilar_cfg_type cfg_in;
  rilar_cfg_type cfg;
  logic [3:0]    count_eff;
  logic          running;
  logic [7:0]    mod_err;
  logic [5:0]    words;
  logic [5:0]    seg_cnt;
  logic [5:0]    pidx;
  logic [9:0]    param_addr;
  logic [15:0]   param_data;
  logic [9:0]    rd_buf_addr;
  logic [15:0]   dev_dst;
  logic [15:0]   tx_src;
  logic [9:0]    tx_dst;
  logic [15:0]   rx_word;
  logic [19:0]   wait_limit;
  logic          push;
  logic [ENTRY_W-1:0] push_data;
  logic          in_ready;
  logic          out_valid;
  logic          out_ready;
  logic [ENTRY_W-1:0] out_data;
  logic          rd_buf;
  logic          rd_dev;
  logic          drain_buf;
  logic          drain_dev;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration store and word buffer
  assign cfg_in = '{legacy: cfg_legacy, stations: cfg_stations, retries: cfg_retries,
                    line_err: cfg_line_err, rx_head: cfg_rx_head, tx_head: cfg_tx_head,
                    fault_en: cfg_fault_en, fault_head: cfg_fault_head, err_en: cfg_err_en,
                    err_head: cfg_err_head, rt_mods: cfg_rt_mods};

  rilar_cfg_mem u_cfg (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (cfg_wr),
    .wr_idx  (cfg_idx),
    .wr_data (cfg_in),
    .rd_idx  (s_nxt.mod),
    .rd_data (cfg)
  );

  // A stalled sink blocks further reads through in_ready, so no word is lost
  rilar_buf2 #(.W(ENTRY_W)) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (push_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address and data helpers
  assign count_eff = (module_count > MAX_MODULES) ? MAX_MODULES : module_count;
  assign running   = (cpu_state != CPU_STOP);
  assign mod_err   = hw_error | rom_error;
  // Odd station totals take one extra station
  assign words     = 6'((({1'b0, s_r.stations}) + 8'h01) >> 1);
  assign pidx      = cfg.legacy ? s_r.idx : s_r.idx + 6'h01;
  assign param_addr = (pidx == 6'h00) ? BW_STATIONS :
                      (pidx == 6'h01) ? BW_RETRIES : BW_LINE_ERR;
  assign param_data = (pidx == 6'h00) ? {9'h000, s_r.stations} :
                      (pidx == 6'h01) ? {10'h000, (cfg.retries > MAX_RETRIES) ?
                                         MAX_RETRIES : cfg.retries} :
                      {14'h0000, cfg.line_err};
  assign tx_src  = {4'h0, cfg.tx_head[15:4]} + {10'h000, s_r.idx};
  assign tx_dst  = BW_TX_BASE + {4'h0, s_r.idx};
  assign rx_word = (s_r.seg == SEG_RX && s_r.stations[0] && s_r.idx == s_r.cnt - 6'h01) ?
                   {8'h00, buf_rdata[7:0]} : buf_rdata;

  always_comb begin
    seg_cnt     = 6'h00;
    rd_buf_addr = BW_STATIONS;
    dev_dst     = 16'h0000;
    case (s_r.seg)
      SEG_PARAM: begin
        seg_cnt = cfg.legacy ? PARAM_WORDS_LEG : PARAM_WORDS_EXT;
      end
      SEG_RX: begin
        seg_cnt     = words;
        rd_buf_addr = BW_RX_BASE + {4'h0, s_r.idx};
        dev_dst     = {4'h0, cfg.rx_head[15:4]} + {10'h000, s_r.idx};
      end
      SEG_TX: begin
        seg_cnt = words;
      end
      SEG_FLT: begin
        seg_cnt = !cfg.fault_en ? 6'h00 : cfg.legacy ? FLT_WORDS_LEG : FLT_WORDS_EXT;
        rd_buf_addr = (s_r.idx == FLT_EXT_INDEX) ? BW_FLT_EXT : BW_FLT_BASE + {4'h0, s_r.idx};
        dev_dst     = cfg.fault_head + {10'h000, s_r.idx};
      end
      SEG_ERR: begin
        seg_cnt = !cfg.err_en ? 6'h00 : cfg.legacy ? 6'h01 : {3'h0, cfg.rt_mods} + 6'h01;
        rd_buf_addr = cfg.legacy ? BW_ERR_LEG : BW_ERR_EXT + {4'h0, s_r.idx};
        dev_dst     = cfg.err_head + {10'h000, s_r.idx};
      end
      default: begin
        seg_cnt = 6'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    s_nxt     = s_r;
    push      = 1'b0;
    push_data = '0;
    rd_buf    = 1'b0;
    rd_dev    = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (end_of_scan && running) begin
          if (count_eff == 4'h0) begin
            s_nxt.started = 1'b1;
          end else begin
            s_nxt.st      = ST_LOAD;
            s_nxt.mod     = 3'h0;
            s_nxt.overrun = 1'b0;
          end
        end
      end
      ST_LOAD: begin
        s_nxt.seg      = s_r.started ? SEG_RX : SEG_PARAM;
        s_nxt.stations = (cfg.stations > MAX_STATIONS) ? MAX_STATIONS : cfg.stations;
        if (mod_err[s_r.mod]) begin
          s_nxt.st = ST_NEXT;
        end else if (!cfg.legacy) begin
          s_nxt.st = ST_ROM;
        end else begin
          s_nxt.st = ST_SETUP;
        end
      end
      ST_ROM: begin
        rd_buf = 1'b1;
        if (buf_ack) begin
          s_nxt.stations = (buf_rdata > {9'h000, MAX_STATIONS}) ? MAX_STATIONS : buf_rdata[6:0];
          s_nxt.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        s_nxt.idx = 6'h00;
        s_nxt.cnt = seg_cnt;
        if (s_r.seg == SEG_END) begin
          s_nxt.st = ST_NEXT;
        end else if (seg_cnt == 6'h00) begin
          s_nxt.seg = rilar_seg_type'(s_r.seg + 3'h1);
        end else begin
          s_nxt.st = ST_COPY;
        end
      end
      ST_COPY: begin
        if (s_r.idx == s_r.cnt) begin
          s_nxt.st = ST_DRAIN;
        end else if (in_ready) begin
          if (s_r.seg == SEG_PARAM) begin
            push      = 1'b1;
            push_data = {1'b1, 6'h00, param_addr, param_data};
            s_nxt.idx = s_r.idx + 6'h01;
          end else if (s_r.seg == SEG_TX) begin
            rd_dev = 1'b1;
            if (dev_ack) begin
              push      = 1'b1;
              push_data = {1'b1, 6'h00, tx_dst, dev_rdata};
              s_nxt.idx = s_r.idx + 6'h01;
            end
          end else begin
            rd_buf = 1'b1;
            if (buf_ack) begin
              push      = 1'b1;
              push_data = {1'b0, dev_dst, rx_word};
              s_nxt.idx = s_r.idx + 6'h01;
            end
          end
        end
      end
      ST_DRAIN: begin
        // Direction flips between segments, so the buffer must be empty first
        if (!out_valid) begin
          s_nxt.st  = ST_SETUP;
          s_nxt.seg = rilar_seg_type'(s_r.seg + 3'h1);
        end
      end
      ST_NEXT: begin
        if ({1'b0, s_r.mod} + 4'h1 >= count_eff) begin
          s_nxt.st      = ST_IDLE;
          s_nxt.started = running;
        end else begin
          s_nxt.mod = s_r.mod + 3'h1;
          s_nxt.st  = ST_LOAD;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase

    if (!running && !cfg_stop_continue) begin
      s_nxt.started = 1'b0;
    end
    if (cfg_wr) begin
      s_nxt.legacy[cfg_idx] = cfg_legacy;
    end
    s_nxt.points = 9'h000;
    for (int i = 0; i < 8; i++) begin
      s_nxt.start[i] = s_nxt.started && (4'(i) < count_eff);
      if (4'(i) < count_eff) begin
        s_nxt.points = s_nxt.points + (s_r.legacy[i] ? PTS_LEGACY : PTS_EXT);
      end
    end
    s_nxt.prio   = {8{cfg_link_priority}};
    s_nxt.retain = {8{cfg_retain_faulty}};
    if (buf_req && !buf_ack && s_r.prio[s_r.mod]) begin
      s_nxt.wait_cnt = (s_r.wait_cnt == 20'hFFFFF) ? s_r.wait_cnt : s_r.wait_cnt + 20'h00001;
    end else begin
      s_nxt.wait_cnt = 20'h00000;
    end
    if (s_r.wait_cnt >= wait_limit) begin
      s_nxt.overrun = 1'b1;
    end
  end

  assign wait_limit = 20'(WAIT_BASE) + 20'(WAIT_STEP) * {13'h0000, cfg_sep_stations};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '{st: ST_IDLE, seg: SEG_PARAM, legacy: 8'hFF, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port muxing; reads and drain writes never meet on one port
  assign drain_buf = out_valid && out_data[ENTRY_W-1] && !rd_buf;
  assign drain_dev = out_valid && !out_data[ENTRY_W-1] && !rd_dev;
  assign out_ready = (drain_buf && buf_ack) || (drain_dev && dev_ack);

  assign buf_req   = rd_buf || drain_buf;
  assign buf_we    = drain_buf;
  assign buf_mod   = s_r.mod;
  assign buf_addr  = drain_buf ? out_data[DW+BUF_AW-1:DW] : (s_r.st == ST_ROM) ?
                     BW_STATIONS : rd_buf_addr;
  assign buf_wdata = out_data[DW-1:0];
  assign dev_req   = rd_dev || drain_dev;
  assign dev_we    = drain_dev;
  assign dev_addr  = drain_dev ? out_data[DW+DEV_AW-1:DW] : tx_src;
  assign dev_wdata = out_data[DW-1:0];

  assign link_start                  = s_r.start;
  assign access_priority_select      = s_r.prio;
  assign faulty_station_clear_select = s_r.retain;
  assign io_points_total             = s_r.points;
  assign busy                        = (s_r.st != ST_IDLE);
  assign wait_overrun                = s_r.overrun;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_start_first_scan: assert property (!s_r.started |-> link_start == 8'h00)
    else $error("link start high before first scan completed");
  chk_start_count_mask: assert property (s_nxt.started
    |=> link_start == (8'hFF >> (4'h8 - $past(count_eff))))
    else $error("link start does not match configured modules");
  chk_stopped_no_batch: assert property (s_r.st == ST_IDLE && cpu_state == CPU_STOP
    |=> s_r.st == ST_IDLE)
    else $error("batch started while CPU stopped");
  chk_zero_count_idle: assert property (s_r.st == ST_IDLE && count_eff == 4'h0
    |=> s_r.st == ST_IDLE)
    else $error("refresh with zero module count");
  chk_error_skip: assert property (s_r.st == ST_LOAD && mod_err[s_r.mod]
    |=> s_r.st == ST_NEXT ##1 !buf_req[*1])
    else $error("errored module was refreshed");
  chk_buf_read_window: assert property (buf_req && !buf_we |-> buf_addr == BW_STATIONS ||
    (buf_addr >= BW_FLT_BASE && buf_addr <= 10'h067) || buf_addr == BW_ERR_LEG ||
    (buf_addr >= BW_RX_BASE && buf_addr <= 10'h08D) ||
    (buf_addr >= BW_FLT_EXT && buf_addr <= 10'h0CB))
    else $error("buffer read outside documented words");
  chk_buf_write_window: assert property (buf_req && buf_we |-> buf_addr == BW_STATIONS ||
    buf_addr == BW_RETRIES || buf_addr == BW_LINE_ERR ||
    (buf_addr >= BW_TX_BASE && buf_addr <= 10'h029))
    else $error("buffer write outside documented words");
  chk_retry_capped: assert property (buf_req && buf_we && buf_addr == BW_RETRIES
    |-> buf_wdata <= {10'h000, MAX_RETRIES})
    else $error("retry count above limit");
  chk_pad_cleared: assert property (push && s_r.seg == SEG_RX && s_r.stations[0] &&
    s_r.idx == s_r.cnt - 6'h01 |-> push_data[15:8] == 8'h00)
    else $error("receive padding not forced off");
  chk_module_order: assert property (s_r.st == ST_NEXT && s_nxt.st == ST_LOAD
    |=> s_r.mod == $past(s_r.mod) + 3'h1)
    else $error("modules serviced out of order");
  chk_wait_flag: assert property (buf_req && !buf_ack && s_r.wait_cnt >= wait_limit
    |=> wait_overrun)
    else $error("overlong link wait not flagged");
endmodule

// ==== common/rilar_pkg.sv ====
// Shared constants and types of the remote I/O link auto refresh engine
package rilar_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS        = 20;
  localparam int WAIT_BASE_NS  = 300000;
  localparam int WAIT_STEP_NS  = 200000;
  // Longest waits, so both round down
  localparam int WAIT_BASE_CYC = WAIT_BASE_NS / CLK_NS;
  localparam int WAIT_STEP_CYC = WAIT_STEP_NS / CLK_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // Limits and widths
  localparam logic [3:0] MAX_MODULES  = 4'h8;
  localparam logic [6:0] MAX_STATIONS = 7'h40;
  localparam logic [5:0] MAX_RETRIES  = 6'h20;
  localparam logic [5:0] DEF_RETRIES  = 6'h05;
  localparam logic [8:0] PTS_LEGACY   = 9'h020;
  localparam logic [8:0] PTS_EXT      = 9'h030;
  localparam int         BUF_AW       = 10;
  localparam int         DEV_AW       = 16;
  localparam int         DW           = 16;
  localparam int         ENTRY_W      = 1 + DEV_AW + DW;

  ////////////////////////////////////////////////////////////////////////////////
  // Master buffer word addresses
  localparam logic [9:0] BW_STATIONS  = 10'h000;
  localparam logic [9:0] BW_RETRIES   = 10'h001;
  localparam logic [9:0] BW_LINE_ERR  = 10'h004;
  localparam logic [9:0] BW_TX_BASE   = 10'h00A;
  localparam logic [9:0] BW_FLT_BASE  = 10'h064;
  localparam logic [9:0] BW_ERR_LEG   = 10'h06B;
  localparam logic [9:0] BW_RX_BASE   = 10'h06E;
  localparam logic [9:0] BW_FLT_EXT   = 10'h0C3;
  localparam logic [9:0] BW_ERR_EXT   = 10'h0C4;

  // Word counts per segment
  localparam logic [5:0] PARAM_WORDS_LEG = 6'h03;
  localparam logic [5:0] PARAM_WORDS_EXT = 6'h02;
  localparam logic [5:0] FLT_WORDS_LEG   = 6'h04;
  localparam logic [5:0] FLT_WORDS_EXT   = 6'h05;
  localparam logic [5:0] FLT_EXT_INDEX   = 6'h04;

  ////////////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [1:0] {
    CPU_STOP  = 2'h0,
    CPU_RUN   = 2'h1,
    CPU_PAUSE = 2'h2,
    CPU_STEP  = 2'h3
  } rilar_cpu_type;

  typedef enum logic [1:0] {
    LE_TEST   = 2'h0,
    LE_OFF    = 2'h1,
    LE_RETAIN = 2'h2
  } rilar_line_err_type;

  typedef enum logic [2:0] {
    SEG_PARAM = 3'h0,
    SEG_RX    = 3'h1,
    SEG_TX    = 3'h2,
    SEG_FLT   = 3'h3,
    SEG_ERR   = 3'h4,
    SEG_END   = 3'h5
  } rilar_seg_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOAD  = 3'h1,
    ST_SETUP = 3'h3,
    ST_COPY  = 3'h2,
    ST_DRAIN = 3'h6,
    ST_NEXT  = 3'h7,
    ST_ROM   = 3'h5
  } rilar_state_type;

  typedef struct packed {
    logic               legacy;
    logic [6:0]         stations;
    logic [5:0]         retries;
    rilar_line_err_type line_err;
    logic [15:0]        rx_head;
    logic [15:0]        tx_head;
    logic               fault_en;
    logic [15:0]        fault_head;
    logic               err_en;
    logic [15:0]        err_head;
    logic [2:0]         rt_mods;
  } rilar_cfg_type;

  localparam rilar_cfg_type CFG_DEFAULT = '{
    legacy: 1'b1, stations: 7'h00, retries: DEF_RETRIES, line_err: LE_RETAIN,
    rx_head: 16'h0000, tx_head: 16'h0000, fault_en: 1'b0, fault_head: 16'h0000,
    err_en: 1'b0, err_head: 16'h0000, rt_mods: 3'h0};

endpackage

// ==== design/rilar_buf2.sv ====
// Two-entry valid/ready buffer between word source and word sink
`timescale 1ns/10ps
module rilar_buf2 #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  typedef struct packed {
    logic [1:0]   n;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } rilar_buf_type;

  rilar_buf_type s_r;
  rilar_buf_type s_nxt;
  logic          push;
  logic          pop;

  assign in_ready  = (s_r.n != 2'h2);
  assign out_valid = (s_r.n != 2'h0);
  assign out_data  = s_r.e0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (pop) begin
      s_nxt.e0 = s_r.e1;
    end
    if (push) begin
      if (s_r.n == 2'h0 || (s_r.n == 2'h1 && pop)) begin
        s_nxt.e0 = in_data;
      end else begin
        s_nxt.e1 = in_data;
      end
    end
    s_nxt.n = s_r.n + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ==== design/rilar_cfg_mem.sv ====
// Per-module link configuration store with registered read
`timescale 1ns/10ps
module rilar_cfg_mem
  import rilar_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          wr_en,
  input  wire logic [2:0]    wr_idx,
  input  rilar_cfg_type      wr_data,
  input  wire logic [2:0]    rd_idx,
  output rilar_cfg_type      rd_data
);
  typedef struct packed {
    rilar_cfg_type [7:0] ent;
    rilar_cfg_type       rd;
  } rilar_mem_type;

  rilar_mem_type s_r;
  rilar_mem_type s_nxt;

  assign rd_data = s_r.rd;

  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      s_nxt.ent[wr_idx] = wr_data;
    end
    s_nxt.rd = s_r.ent[rd_idx];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_r <= {9{CFG_DEFAULT}};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ==== verification/rilar_buf_model.sv ====
// Behavioural buffer memory of eight link master modules
`timescale 1ns/10ps
module rilar_buf_model (
  input  wire logic        clock,
  input  wire logic        slow,
  input  wire logic        buf_req,
  input  wire logic        buf_we,
  input  wire logic [2:0]  buf_mod,
  input  wire logic [9:0]  buf_addr,
  input  wire logic [15:0] buf_wdata,
  output logic             buf_ack,
  output logic [15:0]      buf_rdata
);
  logic [15:0] mem [0:8191];
  logic [1:0]  wait_cnt = 2'h0;
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 16'hA5C3 ^ i[15:0];
    end
  end
  // Slow mode stalls two cycles, so the engine must hold its request
  assign buf_ack = buf_req && (!slow || wait_cnt == 2'h2);
  // Outside an answer the data shows the inverse, so stale reads are caught
  assign buf_rdata = buf_ack ? mem[{buf_mod, buf_addr}] : ~mem[{buf_mod, buf_addr}];
  always @(posedge clock) begin
    wait_cnt <= (buf_req && !buf_ack) ? wait_cnt + 2'h1 : 2'h0;
    if (buf_ack && buf_we) begin
      mem[{buf_mod, buf_addr}] <= buf_wdata;
    end
  end
endmodule

// ==== verification/tb_rilar_engine.sv ====
// Self-checking bench of the auto refresh engine
`timescale 1ns/10ps
module tb_rilar_engine;
  import rilar_pkg::*;
  logic        clock, rst, end_of_scan, cfg_wr, cfg_legacy, cfg_fault_en, cfg_err_en, slow;
  logic        cfg_stop_continue, cfg_link_priority, cfg_retain_faulty, busy, went_busy;
  logic        wait_overrun, buf_req, buf_we, buf_ack, dev_req, dev_we, dev_ack;
  logic [2:0]  cfg_idx, cfg_rt_mods, buf_mod;
  logic [3:0]  module_count;
  logic [5:0]  cfg_retries;
  logic [6:0]  cfg_sep_stations, cfg_stations;
  logic [7:0]  hw_error, rom_error, link_start, access_priority_select;
  logic [7:0]  faulty_station_clear_select;
  logic [8:0]  io_points_total;
  logic [9:0]  buf_addr;
  logic [15:0] cfg_rx_head, cfg_tx_head, cfg_fault_head, cfg_err_head, buf_wdata, buf_rdata;
  logic [15:0] dev_addr, dev_wdata, dev_rdata;
  logic [15:0] dev_mem [0:65535];
  rilar_cpu_type      cpu_state;
  rilar_line_err_type cfg_line_err;
  int          err_count, comparisons;

  rilar_engine #(.WAIT_BASE(20), .WAIT_STEP(10)) u_dut (.*);
  rilar_buf_model u_buf (.*);

  ////////////////////////////////////////////////////////////////////////////////
  // Device memory answers in the request cycle
  assign dev_ack = dev_req;
  assign dev_rdata = dev_mem[dev_addr];
  always @(posedge clock) begin
    if (dev_req && dev_we) begin
      dev_mem[dev_addr] <= dev_wdata;
    end
  end

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One end-of-scan pulse, then a bounded wait for the batch to finish
  task automatic batch;
    int n;
    @(posedge clock);
    end_of_scan <= 1'b1;
    @(posedge clock);
    end_of_scan <= 1'b0;
    for (n = 0; n < 4000; n++) begin
      @(negedge clock);
      if (n == 0) went_busy = busy;
      if (busy === 1'b0) break;
    end
    if (n == 4000) begin
      err_count++;
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    comparisons = 0;
    {rst, slow, cfg_legacy, cfg_retain_faulty} = 4'hF;
    {end_of_scan, cfg_wr, cfg_stop_continue, cfg_link_priority} = 4'h0;
    {cfg_fault_en, cfg_err_en, cfg_idx, cfg_rt_mods} = 8'h00;
    cpu_state = CPU_STOP;
    module_count = 4'h2;
    cfg_sep_stations = 7'h00;
    cfg_stations = 7'h03;
    cfg_retries = 6'h07;
    cfg_line_err = LE_OFF;
    cfg_rx_head = 16'h0100;
    cfg_tx_head = 16'h0200;
    cfg_fault_head = 16'h0000;
    cfg_err_head = 16'h0000;
    hw_error = 8'h02;
    rom_error = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      dev_mem[i] = 16'h3C00 ^ i[15:0];
    end
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // Module 0 legacy, module 1 extended, written back to back
    @(posedge clock);
    cfg_wr <= 1'b1;
    @(posedge clock);
    cfg_idx <= 3'h1;
    cfg_legacy <= 1'b0;
    {cfg_fault_en, cfg_err_en, cfg_rt_mods} <= 5'h19;
    {cfg_rx_head, cfg_fault_head, cfg_err_head} <= {16'h0400, 16'h0300, 16'h0310};
    @(posedge clock);
    cfg_wr <= 1'b0;
    batch();
    check("busy in stop", 16'h0000, {15'h0, went_busy});
    check("start in stop", 16'h0000, {8'h00, link_start});
    $display("test stop done");
    @(posedge clock);
    cpu_state <= CPU_RUN;
    batch();
    check("start", 16'h0003, {8'h00, link_start});
    check("points", 16'h0050, {7'h00, io_points_total});
    check("clear select", 16'h00FF, {8'h00, faulty_station_clear_select});
    check("priority", 16'h0000, {8'h00, access_priority_select});
    check("rx word 0", 16'hA5C3 ^ 16'd110, dev_mem[16'h0010]);
    check("rx pad", (16'hA5C3 ^ 16'd111) & 16'h00FF, dev_mem[16'h0011]);
    check("rx end", 16'h3C12, dev_mem[16'h0012]);
    check("tx word 0", 16'h3C20, u_buf.mem[10]);
    check("tx word 1", 16'h3C21, u_buf.mem[11]);
    check("stations", 16'h0003, u_buf.mem[0]);
    check("retries", 16'h0007, u_buf.mem[1]);
    check("line error", 16'h0001, u_buf.mem[4]);
    check("errored module", 16'hA5C3 ^ 16'h0401, u_buf.mem[1025]);
    $display("test run done");
    @(posedge clock);
    cfg_link_priority <= 1'b1;
    cpu_state <= CPU_PAUSE;
    hw_error <= 8'h00;
    batch();
    check("busy in pause", 16'h0001, {15'h0, went_busy});
    check("link priority", 16'h00FF, {8'h00, access_priority_select});
    check("wait overrun", 16'h0000, {15'h0, wait_overrun});
    // Module 1 is extended; its master word 0 exceeds 64, so 64 stations apply
    check("ext rx last", 16'hA5C3 ^ 16'h048D, dev_mem[16'h005F]);
    check("ext rx end", 16'h3C60, dev_mem[16'h0060]);
    check("ext tx last", 16'h3C3F, u_buf.mem[1065]);
    check("ext fault", 16'hA5C3 ^ 16'h04C3, dev_mem[16'h0304]);
    check("ext error", 16'hA5C3 ^ 16'h04C5, dev_mem[16'h0311]);
    check("ext error end", 16'h3F12, dev_mem[16'h0312]);
    @(posedge clock);
    cpu_state <= CPU_STOP;
    cfg_stop_continue <= 1'b1;
    repeat (3) @(negedge clock);
    check("start continued", 16'h0003, {8'h00, link_start});
    @(posedge clock);
    cfg_stop_continue <= 1'b0;
    repeat (3) @(negedge clock);
    check("start stopped", 16'h0000, {8'h00, link_start});
    $display("test pause and stop done");
    test_done();
  end
endmodule
